// ### hdl/pac_pkg.sv
// Purpose: Shared constants for the phase adjust register control block.
// Assumes: Register index and data are eight bits wide, as on the two-wire bus.
// Notes: Field positions and codes are named here; the bench passes register indices and the reset code as literals.
package pac_pkg;
	localparam int BYTE_W = 8;
	localparam int TAP_W = 6;
	localparam logic [7:0] IDX_SYNC_CTRL = 8'h00;
	localparam logic [7:0] IDX_PHASE_SEL = 8'h04;
	localparam logic [7:0] IDX_PHASE_RES = 8'h05;
	localparam logic [7:0] IDX_SW_RESET = 8'h08;
	localparam int SYNC_EDGE_BIT = 2;
	localparam int PHASE_EN_BIT = 7;
	localparam logic [3:0] SW_RESET_PHASE_CODE = 4'ha;
	localparam logic [1:0] RES_16 = 2'h0;
	localparam logic [1:0] RES_32 = 2'h1;
	localparam logic [1:0] RES_64 = 2'h3;
	localparam logic [5:0] MAX_SEL_16 = 6'h0f;
	localparam logic [5:0] MAX_SEL_32 = 6'h1f;
	localparam logic [5:0] MAX_SEL_64 = 6'h3f;
	localparam logic [7:0] RESET_SYNC_CTRL = 8'h00;
	localparam logic [7:0] RESET_PHASE_SEL = 8'h80;
	localparam logic [1:0] RESET_PHASE_RES = 2'h0;
	localparam logic [6:0] DEFAULT_BUS_ADDR = 7'h26;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	// The clock fall that closes a start condition wraps the bit count to zero.
	localparam logic [3:0] BIT_PRE = 4'hf;
	localparam logic HALF_RATE_PHASE = 1'b0;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_INDEX,
		ST_WDATA,
		ST_RDATA
	} pac_bus_state_type;
endpackage : pac_pkg

// ### hdl/pac_phase_delay_unit.sv
// Purpose: Converts the delay selection into a tap count on a 64-step scale.
// Assumes: Inputs come from registers on the same clock.
// Notes: Output is registered; one cycle behind its inputs.
`timescale 1ns/1ps
`default_nettype none
module pac_phase_delay_unit (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic [5:0] select_i,
	input wire logic [1:0] resolution_i,
	output logic [5:0] taps_o,
	output logic bypass_o
);
	wire [5:0] max_sel;
	wire [5:0] sat_sel;
	wire [5:0] scaled;
	wire [5:0] taps_d;

	////////////////////////////////////////////////////////////////////////////
	// The reserved resolution code falls back to sixteen elements.
	assign max_sel = (resolution_i == pac_pkg::RES_64) ? pac_pkg::MAX_SEL_64 :
		(resolution_i == pac_pkg::RES_32) ? pac_pkg::MAX_SEL_32 : pac_pkg::MAX_SEL_16;
	assign sat_sel = (select_i > max_sel) ? max_sel : select_i;
	// Delay fraction is selected over total, so scale up to sixty-fourths.
	assign scaled = (resolution_i == pac_pkg::RES_64) ? sat_sel :
		(resolution_i == pac_pkg::RES_32) ? {sat_sel[4:0], 1'b0} : {sat_sel[3:0], 2'b00};
	assign taps_d = enable_i ? scaled : 6'h00;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			taps_o <= 6'h00;
			bypass_o <= 1'b1;
		end else begin
			taps_o <= taps_d;
			bypass_o <= !enable_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	AST_BYPASS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!enable_i |=> (taps_o == 6'h00) && bypass_o)
		else $error("Disabled delay chain is not bypassed.");
	AST_SAT_16: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		enable_i && (resolution_i == pac_pkg::RES_16) && (select_i > pac_pkg::MAX_SEL_16)
		|=> taps_o == 6'h3c)
		else $error("Sixteen element delay does not saturate.");
	AST_SCALE_32: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		enable_i && (resolution_i == pac_pkg::RES_32) && (select_i <= pac_pkg::MAX_SEL_32)
		|=> taps_o == {$past(select_i[4:0]), 1'b0})
		else $error("Thirty-two element delay is scaled wrongly.");
endmodule : pac_phase_delay_unit
`default_nettype wire

// ### hdl/pac_phase_adjust_ctrl.sv
// Purpose: Two-wire register access, sync edge alignment and half-rate clock control.
// Assumes: MCLK_I is the output clock; bus pins and sync arrive asynchronously.
// Notes: Sub-cycle delay is reported as a tap count for the analog delay chain.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Low index nibble increments after each data byte.
// - Upper index nibble never auto-increments.
// - Delay equals period times selected over total.
// - Resolution code picks 16, 32 or 64.
// - Enable clear bypasses the delay chain.
// - Resolution loads only on software reset code.
// - Edge select bit picks rising or falling sync.
// - Function output follows first clock after edge.
// - Half-rate clock fixed phase at function fall.
// - Negative half-rate output complements positive one.
// - Reset restores register defaults.
module pac_phase_adjust_ctrl #(
	parameter logic [6:0] BUS_ADDR = pac_pkg::DEFAULT_BUS_ADDR
) (
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic HSYNC_I,
	output logic FUNCTION_OUTPUT_O,
	output logic CLK2_O,
	output logic CLK2P_O,
	output logic CLK2N_O,
	output logic [5:0] PHASE_TAPS_O,
	output logic PHASE_BYPASS_O
);
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic [1:0] hs_sync_q;
	logic scl_q;
	logic sda_q;
	logic hs_q;
	pac_pkg::pac_bus_state_type state_q;
	logic [3:0] cnt_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [7:0] idx_q;
	logic rw_q;
	logic sda_oe_q;
	logic sda_o_q;
	logic [7:0] sync_ctrl_q;
	logic [7:0] phase_sel_q;
	logic [1:0] res_pend_q;
	logic [1:0] res_work_q;
	logic function_output_q;
	logic half_q;
	logic half_n_q;

	function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic [7:0] sc,
		input logic [7:0] ps, input logic [1:0] rp);
		if (idx == pac_pkg::IDX_SYNC_CTRL) begin
			read_reg = sc;
		end else if (idx == pac_pkg::IDX_PHASE_SEL) begin
			read_reg = ps;
		end else if (idx == pac_pkg::IDX_PHASE_RES) begin
			read_reg = {6'h00, rp};
		end else begin
			read_reg = 8'h00;
		end
	endfunction : read_reg

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; edges compare the second stage with a third, delayed copy.
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
			hs_sync_q <= 2'b00;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			hs_q <= 1'b0;
		end else begin
			scl_sync_q <= {scl_sync_q[0], SCL_I};
			sda_sync_q <= {sda_sync_q[0], SDA_I};
			hs_sync_q <= {hs_sync_q[0], HSYNC_I};
			scl_q <= scl_sync_q[1];
			sda_q <= sda_sync_q[1];
			hs_q <= hs_sync_q[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	wire scl_rise = scl_sync_q[1] && !scl_q;
	wire scl_fall = !scl_sync_q[1] && scl_q;
	wire bus_start = scl_sync_q[1] && scl_q && !sda_sync_q[1] && sda_q;
	wire bus_stop = scl_sync_q[1] && scl_q && sda_sync_q[1] && !sda_q;
	wire byte_done = scl_fall && (cnt_q == pac_pkg::BIT_LAST);
	wire ack_done = scl_fall && (cnt_q == pac_pkg::BIT_ACK);
	wire addr_hit = (rx_q[7:1] == BUS_ADDR);
	wire wr_stb = byte_done && (state_q == pac_pkg::ST_WDATA);
	wire rd_stb = byte_done && (state_q == pac_pkg::ST_RDATA);
	// Carry out of the low nibble is dropped, so the group never changes.
	wire [7:0] idx_next = {idx_q[7:4], idx_q[3:0] + 4'h1};
	wire [7:0] rd_byte = read_reg(idx_q, sync_ctrl_q, phase_sel_q, res_pend_q);
	wire sw_reset_hit = wr_stb && (idx_q == pac_pkg::IDX_SW_RESET) &&
		(rx_q[3:0] == pac_pkg::SW_RESET_PHASE_CODE);

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state_q <= pac_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			idx_q <= 8'h00;
			rw_q <= 1'b0;
			sda_oe_q <= 1'b0;
			sda_o_q <= 1'b0;
		end else if (bus_start) begin
			state_q <= pac_pkg::ST_ADDR;
			// Without this the start's own clock fall would be counted as a bit.
			cnt_q <= pac_pkg::BIT_PRE;
			sda_oe_q <= 1'b0;
		end else if (bus_stop) begin
			state_q <= pac_pkg::ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (state_q != pac_pkg::ST_IDLE) begin
			sda_o_q <= 1'b0;
			if (scl_rise && (cnt_q < pac_pkg::BIT_ACK)) begin
				rx_q <= {rx_q[6:0], sda_q};
			end else if (scl_rise && (state_q == pac_pkg::ST_RDATA) && sda_q) begin
				state_q <= pac_pkg::ST_IDLE;
			end
			if (byte_done) begin
				cnt_q <= pac_pkg::BIT_ACK;
				if (state_q == pac_pkg::ST_ADDR) begin
					rw_q <= rx_q[0];
					sda_oe_q <= addr_hit;
					state_q <= addr_hit ? pac_pkg::ST_ADDR : pac_pkg::ST_IDLE;
				end else if (state_q == pac_pkg::ST_INDEX) begin
					idx_q <= rx_q;
					sda_oe_q <= 1'b1;
				end else if (wr_stb) begin
					idx_q <= idx_next;
					sda_oe_q <= 1'b1;
				end else begin
					idx_q <= idx_next;
					sda_oe_q <= 1'b0;
				end
			end else if (ack_done) begin
				cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
				if (state_q == pac_pkg::ST_ADDR) begin
					state_q <= rw_q ? pac_pkg::ST_RDATA : pac_pkg::ST_INDEX;
				end else if (state_q == pac_pkg::ST_INDEX) begin
					state_q <= pac_pkg::ST_WDATA;
				end
				if ((state_q == pac_pkg::ST_RDATA) || ((state_q == pac_pkg::ST_ADDR) && rw_q)) begin
					tx_q <= {rd_byte[6:0], 1'b0};
					sda_oe_q <= !rd_byte[7];
				end
			end else if (scl_fall) begin
				cnt_q <= cnt_q + 4'h1;
				if (state_q == pac_pkg::ST_RDATA) begin
					tx_q <= {tx_q[6:0], 1'b0};
					sda_oe_q <= !tx_q[7];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers; resolution is staged until the software reset code arrives.
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sync_ctrl_q <= pac_pkg::RESET_SYNC_CTRL;
			phase_sel_q <= pac_pkg::RESET_PHASE_SEL;
			res_pend_q <= pac_pkg::RESET_PHASE_RES;
			res_work_q <= pac_pkg::RESET_PHASE_RES;
		end else if (wr_stb) begin
			if (idx_q == pac_pkg::IDX_SYNC_CTRL) begin
				sync_ctrl_q <= rx_q;
			end else if (idx_q == pac_pkg::IDX_PHASE_SEL) begin
				phase_sel_q <= rx_q;
			end else if (idx_q == pac_pkg::IDX_PHASE_RES) begin
				res_pend_q <= rx_q[1:0];
			end else if (sw_reset_hit) begin
				res_work_q <= res_pend_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sync edge alignment and half-rate clock.
	wire edge_fall_sel = sync_ctrl_q[pac_pkg::SYNC_EDGE_BIT];
	wire sync_edge = edge_fall_sel ? (hs_q && !hs_sync_q[1]) : (!hs_q && hs_sync_q[1]);
	wire function_output_fall = function_output_q && !sync_edge;
	// A full clock sooner is impossible here; the pulse lands one edge after detection.
	wire half_d = function_output_fall ? pac_pkg::HALF_RATE_PHASE : !half_q;

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			function_output_q <= 1'b0;
			half_q <= 1'b0;
			half_n_q <= 1'b1;
		end else begin
			function_output_q <= sync_edge;
			half_q <= half_d;
			half_n_q <= !half_d;
		end
	end

	pac_phase_delay_unit u_delay (
		.clk_i(MCLK_I),
		.reset_n_i(RESET_N_I),
		.enable_i(phase_sel_q[pac_pkg::PHASE_EN_BIT]),
		.select_i(phase_sel_q[5:0]),
		.resolution_i(res_work_q),
		.taps_o(PHASE_TAPS_O),
		.bypass_o(PHASE_BYPASS_O)
	);

	assign SDA_O = sda_o_q;
	assign SDA_OE_O = sda_oe_q;
	assign FUNCTION_OUTPUT_O = function_output_q;
	assign CLK2_O = half_q;
	assign CLK2P_O = half_q;
	assign CLK2N_O = half_n_q;

	////////////////////////////////////////////////////////////////////////////
	AST_IDX_INC: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		(wr_stb || rd_stb) && !bus_start && !bus_stop |=> idx_q[3:0] == $past(idx_q[3:0]) + 4'h1)
		else $error("Index low nibble did not advance.");
	AST_IDX_UPPER: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		(wr_stb || rd_stb) && !bus_start && !bus_stop |=> idx_q[7:4] == $past(idx_q[7:4]))
		else $error("Index upper nibble changed on increment.");
	AST_RES_DBUF: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		!sw_reset_hit |=> $stable(res_work_q))
		else $error("Working resolution changed without reset code.");
	AST_EDGE: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		!edge_fall_sel && hs_sync_q[1] && !hs_q |=> function_output_q)
		else $error("Rising sync edge did not raise function output.");
	AST_FUNCTION_OUTPUT_PULSE: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		$rose(function_output_q) |-> $past(sync_edge))
		else $error("Function output rose without a sync edge.");
	AST_HALF_FIX: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		function_output_q && !sync_edge |=> half_q == pac_pkg::HALF_RATE_PHASE ##1 half_q != pac_pkg::HALF_RATE_PHASE)
		else $error("Half-rate clock not at fixed phase after function fall.");
	AST_COMPL: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		(CLK2N_O == !CLK2P_O) && (CLK2_O == CLK2P_O))
		else $error("Half-rate outputs disagree.");
endmodule : pac_phase_adjust_ctrl
`default_nettype wire

// ### tb/pac_bus_partner.sv
// Purpose: Two-wire bus master and sync source facing the phase adjust block.
// Assumes: The data line has a pull-up, so a released line reads high.
// Notes: Each bus phase lasts eight clocks, twice the minimum the slave needs.
`timescale 1ns/1ps
`default_nettype none
module pac_bus_partner (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic hsync_o
);
	logic [7:0] rd_byte;
	event rd_done;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		hsync_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic hp;
		repeat (8) @(negedge clk_i);
	endtask : hp
	task automatic start;
		sda_o = 1'b1;
		hp;
		scl_o = 1'b1;
		hp;
		sda_o = 1'b0;
		hp;
		scl_o = 1'b0;
		hp;
	endtask : start
	task automatic stop;
		sda_o = 1'b0;
		hp;
		scl_o = 1'b1;
		hp;
		sda_o = 1'b1;
		hp;
	endtask : stop
	// Data only moves while the clock is low, so no bit looks like a start or stop.
	task automatic bx(input logic b, output logic r);
		sda_o = b;
		hp;
		scl_o = 1'b1;
		hp;
		r = sda_i;
		hp;
		scl_o = 1'b0;
		hp;
	endtask : bx
	task automatic wbyte(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bx(d[i], r);
		end
		bx(1'b1, r);
	endtask : wbyte
	task automatic rbyte(input logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bx(1'b1, rd_byte[i]);
		end
		bx(nack, r);
		->rd_done;
	endtask : rbyte
	// The sync level is held long enough for the two-flop synchroniser.
	task automatic sync(input logic v);
		hsync_o = v;
		repeat (12) @(negedge clk_i);
	endtask : sync
endmodule : pac_bus_partner
`default_nettype wire

// ### tb/phase_adjust_register_control_bench.sv
// Purpose: Self-checking bench for the phase adjust register control block.
// Assumes: Default bus address of the design, 200 MHz clock.
// Notes: Results are queued by the driver and compared by watcher processes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s expected %h seen %h", n, e, g); end end
module phase_adjust_register_control_bench;
	localparam logic [6:0] BA = pac_pkg::DEFAULT_BUS_ADDR;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda_m, hs, sda_o, sda_oe, function_output, c2, c2p, c2n, byp, fseen = 1'b0, fprev = 1'b0;
	logic [5:0] taps;
	logic [7:0] ev, rd_q[$], st_q[$];
	wire logic sda;
	int fail_count = 0, checks = 0, cyc = 0;
	event samp;
	assign sda = sda_m & ~(sda_oe & ~sda_o);
	initial forever #2.5 mclk = ~mclk;
	pac_bus_partner pm (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m), .hsync_o(hs));
	pac_phase_adjust_ctrl dut (.MCLK_I(mclk), .RESET_N_I(rst_n), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .HSYNC_I(hs), .FUNCTION_OUTPUT_O(function_output), .CLK2_O(c2),
		.CLK2P_O(c2p), .CLK2N_O(c2n), .PHASE_TAPS_O(taps), .PHASE_BYPASS_O(byp));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (fail_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// Short transfers only: one index group per transfer.
	task automatic wr(input logic [7:0] idx, input logic [7:0] a, input logic [7:0] b, input int n);
		pm.start;
		pm.wbyte({BA, 1'b0});
		pm.wbyte(idx);
		pm.wbyte(a);
		if (n > 1) pm.wbyte(b);
		pm.stop;
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
		rd_q.push_back(e0);
		rd_q.push_back(e1);
		pm.start;
		pm.wbyte({BA, 1'b0});
		pm.wbyte(idx);
		pm.start;
		pm.wbyte({BA, 1'b1});
		pm.rbyte(1'b0);
		pm.rbyte(1'b1);
		pm.stop;
	endtask : rd
	task automatic note(input logic [7:0] e);
		st_q.push_back(e);
		repeat (4) @(negedge mclk);
		->samp;
	endtask : note
	function automatic logic [5:0] exp_taps(input logic [5:0] s, input logic [1:0] c);
		int tot;
		int m;
		tot = (c == pac_pkg::RES_16) ? 16 : (c == pac_pkg::RES_32) ? 32 : 64;
		m = (s > tot - 1) ? tot - 1 : int'(s);
		return 6'(m * 64 / tot);
	endfunction : exp_taps
	////////////////////////////////////////////////////////////////////////////////
	// The pulse is caught away from the edge that launches it.
	always @(negedge mclk) if (function_output === 1'b1) fseen = 1'b1;
	always @(samp) begin
		ev = st_q.pop_front();
		`CHK("status", ev, {byp, fseen, taps})
		fseen = 1'b0;
	end
	always @(pm.rd_done) begin
		ev = rd_q.pop_front();
		`CHK("read", ev, pm.rd_byte)
	end
	always @(negedge mclk) if (rst_n) begin
		`CHK("clk2n", ~c2p, c2n)
		`CHK("clk2p", c2, c2p)
		if (fprev === 1'b1 && function_output === 1'b0) `CHK("clk2_phase", pac_pkg::HALF_RATE_PHASE, c2)
		fprev = function_output;
		cyc++;
		if (cyc > 60000) begin
			fail_count++;
			wrap_up;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [1:0] codes [4];
		logic [5:0] sel;
		codes = '{pac_pkg::RES_16, pac_pkg::RES_32, pac_pkg::RES_64, pac_pkg::RES_16};
		void'($urandom(32'hbe23));
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		note(8'h00);
		rd(8'h04, 8'h80, 8'h00);
		wr(8'h04, 8'h85, 8'h01, 2);
		note(8'h14);
		wr(8'h08, 8'h0a, 8'h00, 1);
		note(8'h0a);
		// Last pass forces an oversized selection at the coarsest resolution.
		for (int i = 0; i < 4; i++) begin
			sel = (i == 3) ? 6'h3f : 6'($urandom_range(63));
			wr(8'h04, {2'b10, sel}, {6'h00, codes[i]}, 2);
			wr(8'h08, 8'h0a, 8'h00, 1);
			note({2'b00, exp_taps(sel, codes[i])});
		end
		wr(8'h04, 8'h15, 8'h00, 1);
		// A write to a foreign address must be ignored; it would enable the chain.
		pm.start;
		pm.wbyte({BA ^ 7'h01, 1'b0});
		pm.wbyte(8'h04);
		pm.wbyte(8'hbf);
		pm.stop;
		note(8'h80);
		wr(8'h00, 8'h04, 8'h00, 1);
		rd(8'h0f, 8'h00, 8'h04);
		pm.sync(1'b1);
		note(8'h80);
		pm.sync(1'b0);
		note(8'hc0);
		wr(8'h00, 8'h00, 8'h00, 1);
		pm.sync(1'b1);
		note(8'hc0);
		pm.sync(1'b0);
		note(8'h80);
		repeat (4) @(negedge mclk);
		wrap_up;
	end
endmodule : phase_adjust_register_control_bench
`default_nettype wire
